// ===== rtl/low_power_and_mode_select.sv
// low-power state control, watchdog interplay, reset-time mode selection and self-check report
//
// Functional notes
// - stop instruction switches the oscillator off and halts all processing
// - entering stop clears the interrupt mask bit so an interrupt can wake
// - in stop, registers, memory and i/o lines are held unchanged
// - stop ends only on a hardware interrupt or an external reset
// - leaving stop waits 4064 processor cycles for the oscillator to settle
// - wait instruction halts only the processor clock; other clocks keep running
// - in wait, peripherals can interrupt and the watchdog can still reset
// - wait clears the interrupt mask bit; other state is held
// - watchdog is enabled after reset; writing zero to option bit 6 disables it
// - with watchdog enabled a stop instruction is carried out as wait
// - an enabled watchdog that times out resets the device, also in wait
// - with the interrupt pin in normal range, reset release enters user mode
// - the mode-select pin is latched within two cycles after reset release
// - self-check mode branches to the program at 1600 to 17FF and repeats
// - self-check failure shows a static pattern on four report lines, one means off
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

module low_power_and_mode_select #(
    parameter int WDOG_TIMEOUT_CYC = lpm_pkg::WDOG_DEFAULT
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire lpm_pkg::reg_req_t        reg_req,
    output logic [lpm_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic                     stop_exec,
    input  wire logic                     wait_exec,
    input  wire logic                     hw_irq,
    input  wire logic                     watchdog_service,
    input  wire logic                     irq_elevated,
    input  wire logic                     mode_select_pin,
    output lpm_pkg::pwr_ctl_t             pwr_ctl,
    output logic                          mode_valid,
    output logic                          self_check_mode,
    output logic                          user_mode,
    output logic [15:0]                   boot_vector,
    output logic                          report_line_3,
    output logic                          report_line_2,
    output logic                          report_line_1,
    output logic                          report_line_0,
    output logic                          irq_out
);
    import lpm_pkg::*;

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        pwr_state_t          pwr;
        logic [11:0]         stab_cnt;
        logic [WDOG_W-1:0]   wdog_cnt;
        logic [DATA_W-1:0]   option;
        logic [EV_W-1:0]     events;
        logic [EV_W-1:0]     mask;
        logic [3:0]          fail_code;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          strap_cnt;
        logic                self_check;
        logic                mode_valid;
        logic [FLASH_W-1:0]  flash_cnt;
        logic                flash_phase;
        logic [3:0]          report;
        logic                imask_clear;
        logic                wdog_reset;
    } state_t;

    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_TIMEOUT_CYC - 1);

    state_t cur_ff;
    state_t nxt_cur_ff;

    // ---------------------------------------------------------------
    // decoding helpers
    // ---------------------------------------------------------------

    // led pattern per failing unit; one is off, zero is on
    function automatic logic [3:0] fail_pattern(input logic [3:0] code);
        logic [3:0] pat;
        pat = 4'hF;
        unique case (fail_unit_t'(code))
            FAIL_PORT_A:   pat = 4'hF;
            FAIL_PORT_B:   pat = 4'hE;
            FAIL_PORT_C:   pat = 4'hD;
            FAIL_RAM:      pat = 4'hC;
            FAIL_ROM:      pat = 4'hB;
            FAIL_IRQ:      pat = 4'hA;
            FAIL_KEYBOARD: pat = 4'h9;
            FAIL_TIMER:    pat = 4'h7;
            FAIL_PWM:      pat = 4'h6;
            default:       pat = 4'hF;
        endcase
        return pat;
    endfunction

    // register port address match, used by both read and write paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] target);
        return a == target;
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic                wdog_on;
    logic [EV_W-1:0]     ev_set;
    logic [EV_W-1:0]     ev_clr;

    always_comb begin
        nxt_cur_ff             = cur_ff;
        nxt_cur_ff.imask_clear = 1'b0;
        nxt_cur_ff.wdog_reset  = 1'b0;
        nxt_cur_ff.rdata       = '0;
        ev_set                 = '0;
        ev_clr                 = '0;
        wdog_on                = cur_ff.option[WDOG_EN_BIT];

        // power state sequencing
        unique case (cur_ff.pwr)
            PWR_RUN: begin
                if (stop_exec && wdog_on) begin
                    // a running watchdog turns stop into wait
                    nxt_cur_ff.pwr         = PWR_WAIT;
                    nxt_cur_ff.imask_clear = 1'b1;
                    ev_set[EV_WAIT]        = 1'b1;
                end else if (stop_exec) begin
                    nxt_cur_ff.pwr         = PWR_STOP;
                    nxt_cur_ff.imask_clear = 1'b1;
                    ev_set[EV_STOP]        = 1'b1;
                end else if (wait_exec) begin
                    nxt_cur_ff.pwr         = PWR_WAIT;
                    nxt_cur_ff.imask_clear = 1'b1;
                    ev_set[EV_WAIT]        = 1'b1;
                end
            end
            PWR_STOP: begin
                // only an interrupt leaves stop here; reset acts asynchronously
                if (hw_irq) begin
                    nxt_cur_ff.pwr      = PWR_RECOVER;
                    nxt_cur_ff.stab_cnt = '0;
                end
            end
            PWR_RECOVER: begin
                // oscillator runs but processor waits for it to settle
                if (cur_ff.stab_cnt == STAB_LAST) begin
                    nxt_cur_ff.pwr  = PWR_RUN;
                    ev_set[EV_WAKE] = 1'b1;
                end else begin
                    nxt_cur_ff.stab_cnt = cur_ff.stab_cnt + 12'h001;
                end
            end
            PWR_WAIT: begin
                // any interrupt, peripheral or timer included, ends wait
                if (hw_irq) begin
                    nxt_cur_ff.pwr  = PWR_RUN;
                    ev_set[EV_WAKE] = 1'b1;
                end
            end
        endcase

        // watchdog runs in run and wait; stop is unreachable while it is on
        if (!wdog_on || watchdog_service) begin
            nxt_cur_ff.wdog_cnt = '0;
        end else if (cur_ff.wdog_cnt == WDOG_LAST) begin
            nxt_cur_ff.wdog_cnt   = '0;
            nxt_cur_ff.wdog_reset = 1'b1;
            ev_set[EV_WDOG]       = 1'b1;
        end else begin
            nxt_cur_ff.wdog_cnt = cur_ff.wdog_cnt + WDOG_W'(1);
        end

        // reset-time strap capture: counter starts at zero on release
        if (cur_ff.strap_cnt != STRAP_DONE) begin
            nxt_cur_ff.strap_cnt = cur_ff.strap_cnt + 2'h1;
        end
        if (cur_ff.strap_cnt == STRAP_SAMPLE) begin
            // elevated interrupt level plus high pin picks self
            nxt_cur_ff.self_check = irq_elevated && mode_select_pin;
            nxt_cur_ff.mode_valid = 1'b1;
        end

        // self-check indicator: flash while passing, static code on failure
        nxt_cur_ff.flash_cnt = cur_ff.flash_cnt + FLASH_W'(1);
        if (cur_ff.flash_cnt == '1) begin
            nxt_cur_ff.flash_phase = !cur_ff.flash_phase;
        end
        if (!cur_ff.self_check) begin
            nxt_cur_ff.report = 4'hF;                       // all leds off outside self-check
        end else if (cur_ff.fail_code == FAIL_NONE) begin
            nxt_cur_ff.report = {4{cur_ff.flash_phase}};
        end else begin
            nxt_cur_ff.report = fail_pattern(cur_ff.fail_code);
        end

        // register writes
        if (reg_req.wr) begin
            if (addr_hit(reg_req.addr, OPTION_ADDR)) begin
                nxt_cur_ff.option = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, EVENT_ADDR)) begin
                ev_clr = reg_req.wdata[EV_W-1:0];
            end
            if (addr_hit(reg_req.addr, MASK_ADDR)) begin
                nxt_cur_ff.mask = reg_req.wdata[EV_W-1:0];
            end
            if (addr_hit(reg_req.addr, REPORT_ADDR)) begin
                nxt_cur_ff.fail_code = reg_req.wdata[3:0];
            end
        end
        // a new event wins over a clear in the same cycle
        nxt_cur_ff.events = (cur_ff.events & ~ev_clr) | ev_set;

        // register reads, data one cycle later; unmapped reads give zero
        if (reg_req.rd) begin
            if (addr_hit(reg_req.addr, OPTION_ADDR)) begin
                nxt_cur_ff.rdata = cur_ff.option;
            end else if (addr_hit(reg_req.addr, EVENT_ADDR)) begin
                nxt_cur_ff.rdata = DATA_W'(cur_ff.events);
            end else if (addr_hit(reg_req.addr, MASK_ADDR)) begin
                nxt_cur_ff.rdata = DATA_W'(cur_ff.mask);
            end else if (addr_hit(reg_req.addr, REPORT_ADDR)) begin
                nxt_cur_ff.rdata = DATA_W'(cur_ff.fail_code);
            end else if (addr_hit(reg_req.addr, STATE_ADDR)) begin
                nxt_cur_ff.rdata = {2'b00, cur_ff.self_check, cur_ff.mode_valid,
                                    2'b00, cur_ff.pwr};
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset is asynchronous; watchdog comes up enabled
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cur_ff             <= '0;
            cur_ff.pwr         <= PWR_RUN;
            cur_ff.option      <= OPTION_RESET;
            cur_ff.events      <= EV_RESET;
            cur_ff.report      <= 4'hF;
            cur_ff.flash_phase <= 1'b1;
        end else begin
            cur_ff <= nxt_cur_ff;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // oscillator off only in stop; hold everything outside run
    assign pwr_ctl.osc_run     = (cur_ff.pwr != PWR_STOP);
    assign pwr_ctl.cpu_clk_run = (cur_ff.pwr == PWR_RUN);
    assign pwr_ctl.hold_state  = (cur_ff.pwr != PWR_RUN);
    assign pwr_ctl.imask_clear = cur_ff.imask_clear;
    assign pwr_ctl.wdog_reset  = cur_ff.wdog_reset;

    // mode outputs settle once the strap has been taken
    assign mode_valid      = cur_ff.mode_valid;
    assign self_check_mode = cur_ff.mode_valid && cur_ff.self_check;
    assign user_mode       = cur_ff.mode_valid && !cur_ff.self_check;
    assign boot_vector     = cur_ff.self_check ? SELF_CHECK_BASE : USER_RESET_VEC;

    // report lines come straight from the register
    assign report_line_3 = cur_ff.report[3];
    assign report_line_2 = cur_ff.report[2];
    assign report_line_1 = cur_ff.report[1];
    assign report_line_0 = cur_ff.report[0];

    assign reg_rdata = cur_ff.rdata;
    assign irq_out   = |(cur_ff.events & cur_ff.mask);

endmodule

// ===== rtl/lpm_pkg.sv
// package: constants, register map and carriers for the low-power and mode-select block
package lpm_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses on the 8-bit register port)
    // ---------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  OPTION_ADDR     = 8'h1D;
    localparam logic [7:0]  EVENT_ADDR      = 8'h20;
    localparam logic [7:0]  MASK_ADDR       = 8'h21;
    localparam logic [7:0]  REPORT_ADDR     = 8'h22;
    localparam logic [7:0]  STATE_ADDR      = 8'h23;

    // option register: watchdog enable bit and reset value
    localparam int          WDOG_EN_BIT     = 6;
    localparam logic [7:0]  OPTION_RESET    = 8'h40;

    // event bit positions
    localparam int          EV_STOP         = 0;
    localparam int          EV_WAIT         = 1;
    localparam int          EV_WAKE         = 2;
    localparam int          EV_WDOG         = 3;
    localparam int          EV_W            = 4;
    localparam logic [3:0]  EV_RESET        = 4'h0;

    // state register bit positions
    localparam int          ST_MODE_VALID   = 4;
    localparam int          ST_SELF_CHECK   = 5;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          STAB_CYCLES     = 4064;   // oscillator settling, in processor cycles
    localparam logic [11:0] STAB_LAST       = 12'(STAB_CYCLES - 1);
    localparam int          WDOG_W          = 17;
    localparam int          WDOG_DEFAULT    = (2 ** 14) * 7;
    localparam logic [1:0]  STRAP_SAMPLE    = 2'h1;   // second cycle after reset release
    localparam logic [1:0]  STRAP_DONE      = 2'h2;
    localparam int          FLASH_W         = 10;     // flash half-period is 2**FLASH_W cycles

    // self-check program entry
    localparam logic [15:0] SELF_CHECK_BASE = 16'h1600;
    localparam logic [15:0] SELF_CHECK_LAST = 16'h17FF;
    localparam logic [15:0] USER_RESET_VEC  = 16'h0000;

    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STOP,
        PWR_WAIT,
        PWR_RECOVER
    } pwr_state_t;

    // failing unit codes as software writes them into the report register
    typedef enum logic [3:0] {
        FAIL_NONE,
        FAIL_PORT_A,
        FAIL_PORT_B,
        FAIL_PORT_C,
        FAIL_RAM,
        FAIL_ROM,
        FAIL_IRQ,
        FAIL_KEYBOARD,
        FAIL_TIMER,
        FAIL_PWM
    } fail_unit_t;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic osc_run;        // oscillator running
        logic cpu_clk_run;    // processor clock running
        logic hold_state;     // freeze registers, memory and i/o lines
        logic imask_clear;    // one-cycle pulse: clear the interrupt mask bit
        logic wdog_reset;     // one-cycle pulse: watchdog resets the device
    } pwr_ctl_t;

endpackage

// ===== sim/lpm_monitor.sv
// checker: power-state, watchdog and strap relations seen at the block's ports
`timescale 1ns/1ps
module lpm_monitor
    import lpm_pkg::*;
#(
    parameter int WDOG_TIMEOUT_CYC = 64
) (
    input wire logic              core_clk,
    input wire logic              reset,
    input wire lpm_pkg::reg_req_t reg_req,
    input wire logic              stop_exec,
    input wire logic              wait_exec,
    input wire logic              hw_irq,
    input wire logic              watchdog_service,
    input wire logic              irq_elevated,
    input wire logic              mode_select_pin,
    input wire lpm_pkg::pwr_ctl_t pwr_ctl,
    input wire logic              mode_valid,
    input wire logic              self_check_mode,
    input wire logic              user_mode,
    input wire logic [15:0]       boot_vector,
    input wire logic              report_line_3,
    input wire logic              report_line_2,
    input wire logic              report_line_1,
    input wire logic              report_line_0
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic        wd_en_ff;
    logic        rec_ff;
    logic [12:0] rec_cnt_ff;
    logic [16:0] quiet_ff;
    logic [1:0]  age_ff;
    // -----------------------------------------------------------
    // shadow of watchdog enable, recovery length, watchdog quiet time
    // -----------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wd_en_ff <= 1'b1;
            rec_ff <= 1'b0;
            rec_cnt_ff <= 13'h0;
            quiet_ff <= 17'h0;
            age_ff <= 2'h0;
        end else begin
            if (reg_req.wr && reg_req.addr == OPTION_ADDR) wd_en_ff <= reg_req.wdata[WDOG_EN_BIT];
            rec_ff <= !pwr_ctl.osc_run || (rec_ff && !pwr_ctl.cpu_clk_run);
            rec_cnt_ff <= (!pwr_ctl.osc_run || pwr_ctl.cpu_clk_run) ? 13'h0 : rec_cnt_ff + 13'h1;
            // any option write may restart the count, so it clears the quiet time too
            quiet_ff <= (reg_req.wr && reg_req.addr == OPTION_ADDR) || watchdog_service
                || pwr_ctl.wdog_reset || !wd_en_ff ? 17'h0 : quiet_ff + 17'h1;
            age_ff <= (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
        end
    end
    a_stop_osc_off: assert property (
        pwr_ctl.cpu_clk_run && stop_exec && !wd_en_ff |=> !pwr_ctl.osc_run && pwr_ctl.hold_state)
        else $error("stop did not halt the oscillator");
    a_stop_as_wait: assert property (
        pwr_ctl.cpu_clk_run && stop_exec && wd_en_ff |=> pwr_ctl.osc_run && !pwr_ctl.cpu_clk_run)
        else $error("stop with watchdog on did not become wait");
    a_mask_clear_pulse: assert property (
        pwr_ctl.cpu_clk_run && (stop_exec || wait_exec) |=> pwr_ctl.imask_clear ##1 !pwr_ctl.imask_clear)
        else $error("interrupt mask clear pulse wrong");
    a_stop_holds: assert property (
        !pwr_ctl.osc_run && !hw_irq |=> !pwr_ctl.osc_run)
        else $error("stop left without interrupt or reset");
    a_recover_len: assert property (
        $rose(pwr_ctl.cpu_clk_run) && rec_ff |-> rec_cnt_ff == 13'(STAB_CYCLES))
        else $error("stop recovery length wrong");
    a_wait_wake: assert property (
        !pwr_ctl.cpu_clk_run && pwr_ctl.osc_run && !rec_ff && hw_irq |=> pwr_ctl.cpu_clk_run)
        else $error("interrupt did not end wait");
    a_wdog_quiet: assert property (
        !wd_en_ff && !$past(wd_en_ff) |-> !pwr_ctl.wdog_reset)
        else $error("disabled watchdog fired");
    a_wdog_bound: assert property (
        quiet_ff <= 17'(WDOG_TIMEOUT_CYC + 2))
        else $error("enabled watchdog did not time out");
    a_strap_time: assert property (
        $rose(mode_valid) |-> age_ff == 2'h2)
        else $error("strap not latched at second edge");
    a_strap_value: assert property (
        $rose(mode_valid) |-> self_check_mode == ($past(irq_elevated) && $past(mode_select_pin)))
        else $error("mode choice wrong");
    a_mode_vector: assert property (
        mode_valid |-> user_mode != self_check_mode
            && boot_vector == (self_check_mode ? SELF_CHECK_BASE : USER_RESET_VEC))
        else $error("mode outputs or vector wrong");
    a_report_off: assert property (
        !self_check_mode && !$past(self_check_mode)
            |-> {report_line_3, report_line_2, report_line_1, report_line_0} == 4'hF)
        else $error("indicators lit outside self-check");
endmodule

// ===== sim/lpm_strap_source.sv
// model of the outside reset and mode-strap circuitry
`timescale 1ns/1ps
module lpm_strap_source (
    input  wire logic core_clk,
    output logic      reset,
    output logic      irq_elevated,
    output logic      mode_select_pin
);
    // power-on: reset already asserted at time zero
    initial begin
        reset = 1'b1;
        irq_elevated = 1'b0;
        mode_select_pin = 1'b0;
    end
    // straps set up before release and held past the latch window
    task automatic pulse_reset(input int len, input logic elev, input logic pin);
        @(posedge core_clk);
        reset <= 1'b1;
        irq_elevated <= elev;
        mode_select_pin <= pin;
        repeat (len) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        irq_elevated <= 1'b0;
        mode_select_pin <= ~pin; // pin reused later: show the opposite level
        #1; // callers look at the mode outputs after they have settled
    endtask
endmodule

// ===== sim/low_power_and_mode_select_tb.sv
// testbench: drives power, register and strap inputs and compares with expected values written in the test
`timescale 1ns/1ps
module low_power_and_mode_select_tb;
    import lpm_pkg::*;
    logic        core_clk, reset, stop_exec, wait_exec, hw_irq, watchdog_service, svc_on;
    logic        irq_elevated, mode_select_pin, mode_valid, self_check_mode, user_mode, irq_out;
    logic        report_line_3, report_line_2, report_line_1, report_line_0, found, elev, pin;
    logic [3:0]  svc_cnt, seen;
    logic [7:0]  rdata, d;
    logic [15:0] boot_vector;
    reg_req_t    req;
    pwr_ctl_t    pc;
    int          err_count, samples_checked, n, exp_ev;
    logic [3:0]  pat [10] = '{4'hF, 4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6};

    lpm_strap_source strap (.core_clk(core_clk), .reset(reset), .irq_elevated(irq_elevated),
        .mode_select_pin(mode_select_pin));
    low_power_and_mode_select #(.WDOG_TIMEOUT_CYC(64)) dut (.core_clk(core_clk), .reset(reset),
        .reg_req(req), .reg_rdata(rdata), .stop_exec(stop_exec), .wait_exec(wait_exec),
        .hw_irq(hw_irq), .watchdog_service(watchdog_service), .irq_elevated(irq_elevated),
        .mode_select_pin(mode_select_pin), .pwr_ctl(pc), .mode_valid(mode_valid),
        .self_check_mode(self_check_mode), .user_mode(user_mode), .boot_vector(boot_vector),
        .report_line_3(report_line_3), .report_line_2(report_line_2),
        .report_line_1(report_line_1), .report_line_0(report_line_0), .irq_out(irq_out));
    // 200 MHz processor clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // periodic watchdog service; turned off only where a timeout is wanted
    always @(posedge core_clk) begin
        svc_cnt <= reset ? 4'h0 : svc_cnt + 4'h1;
        watchdog_service <= svc_on && svc_cnt == 4'h0;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk);
        req <= '{a, v, 1'b0, 1'b0};
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1 d = rdata;
    endtask
    task automatic exec(input logic s, input logic w);
        @(posedge core_clk);
        stop_exec <= s;
        wait_exec <= w;
        @(posedge core_clk);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
        #1;
    endtask
    task automatic wake();
        @(posedge core_clk);
        hw_irq <= 1'b1;
        @(posedge core_clk);
        hw_irq <= 1'b0;
        #1;
    endtask
    // a bounded wait that ran out ends the run
    task automatic need(input logic ok);
        if (!ok) begin
            err_count++;
            close_out();
        end
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {stop_exec, wait_exec, hw_irq} = '0;
        req = '0;
        svc_on = 1'b1;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(11));
        strap.pulse_reset(12, 1'b0, 1'b0);
        rd(OPTION_ADDR); chk("option", 16'(OPTION_RESET), 16'(d));
        rd(STATE_ADDR); chk("state", 16'h0010, 16'(d));
        rd(8'h7F); chk("unmapped", 16'h0, 16'(d));
        wr(EVENT_ADDR, 8'hFF);
        exec(1'b1, 1'b0); chk("stop as wait", 16'h3, 16'({pc.osc_run, pc.imask_clear}));
        rd(STATE_ADDR); chk("wait state", 16'h0012, 16'(d));
        wake(); chk("wait wake", 16'h1, 16'(pc.cpu_clk_run));
        rd(EVENT_ADDR); chk("events", 16'h0006, 16'(d));
        svc_on = 1'b0;
        exec(1'b0, 1'b1);
        found = 1'b0;
        for (n = 0; n < 200 && !found; n++) begin
            @(posedge core_clk); #1 found = pc.wdog_reset;
        end
        need(found);
        svc_on = 1'b1;
        wake();
        rd(EVENT_ADDR); chk("events wdog", 16'h000E, 16'(d));
        wr(OPTION_ADDR, 8'h00); rd(OPTION_ADDR); chk("option off", 16'h0, 16'(d));
        wr(EVENT_ADDR, 8'hFF);
        exp_ev = 0;
        exec(1'b1, 1'b0); chk("stop", 16'h3, 16'({pc.imask_clear, pc.hold_state}));
        for (n = 0; n < 20; n++) begin
            exec(1'($urandom), 1'($urandom)); chk("osc off", 16'h0, 16'(pc.osc_run));
        end
        wake();
        n = 0;
        while (!pc.cpu_clk_run && n < 5000) begin
            @(posedge core_clk); #1 n++;
        end
        chk("recover cycles", 16'(STAB_CYCLES), 16'(n));
        exp_ev = 5;
        wr(MASK_ADDR, 8'h04); chk("irq", 16'(|(exp_ev & 4)), 16'(irq_out));
        wr(EVENT_ADDR, 8'h04); exp_ev = 1; chk("irq clr", 16'h0, 16'(irq_out));
        wr(MASK_ADDR, 8'h01); chk("irq b0", 16'(exp_ev & 1), 16'(irq_out));
        rd(EVENT_ADDR); chk("events", 16'(exp_ev), 16'(d));
        wr(MASK_ADDR, 8'h00); chk("irq mask", 16'h0, 16'(irq_out));
        // random straps, the last one a long power-on reset into self-check
        for (int i = 0; i < 4; i++) begin
            elev = (i == 3) ? 1'b1 : 1'($urandom);
            pin = (i == 3) ? 1'b1 : 1'($urandom);
            strap.pulse_reset((i == 3) ? 4064 : 12, elev, pin);
            chk("self check", 16'(elev & pin), 16'(self_check_mode));
            chk("user", 16'(!(elev & pin)), 16'(user_mode));
            chk("vector", (elev & pin) ? SELF_CHECK_BASE : USER_RESET_VEC, boot_vector);
        end
        seen = {report_line_3, report_line_2, report_line_1, report_line_0};
        found = 1'b0;
        for (n = 0; n < 1100 && !found; n++) begin
            @(posedge core_clk); #1 found = seen !== {report_line_3, report_line_2,
                report_line_1, report_line_0};
        end
        need(found);
        for (int c = 1; c < 10; c++) begin
            wr(REPORT_ADDR, 8'(c));
            @(posedge core_clk); #1 chk("pattern", 16'(pat[c]), 16'({report_line_3,
                report_line_2, report_line_1, report_line_0}));
        end
        close_out();
    end
endmodule

bind low_power_and_mode_select lpm_monitor #(.WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC)) mon (
    .core_clk(core_clk), .reset(reset), .reg_req(reg_req), .stop_exec(stop_exec),
    .wait_exec(wait_exec), .hw_irq(hw_irq), .watchdog_service(watchdog_service),
    .irq_elevated(irq_elevated), .mode_select_pin(mode_select_pin), .pwr_ctl(pwr_ctl),
    .mode_valid(mode_valid), .self_check_mode(self_check_mode), .user_mode(user_mode),
    .boot_vector(boot_vector), .report_line_3(report_line_3), .report_line_2(report_line_2),
    .report_line_1(report_line_1), .report_line_0(report_line_0));
